// ### fault_status_pkg.sv
// Field layout, reset value and parity helper for the fault summary word
package fault_status_pkg;
  localparam int WORD_W = 16;
  localparam int ACQ_W = 10;
  // Field positions within the summary word
  localparam int POS_ANY_FAULT = 15;
  localparam int POS_POR = 14;
  localparam int POS_XFER_ERR = 13;
  localparam int POS_NVM = 12;
  localparam int POS_OVERCURRENT = 11;
  localparam int POS_KEY_LEVEL = 10;
  localparam int POS_OVERHEAT = 9;
  localparam int POS_HEAT_ALERT = 8;
  localparam int POS_UNUSED = 7;
  localparam int POS_WATCHDOG = 6;
  localparam int POS_ENABLE_TO = 5;
  localparam int POS_SUPPLY_LOW = 4;
  localparam int POS_LOGIC_LOW = 3;
  localparam int POS_BOOT_LOW = 2;
  localparam int POS_VDS = 1;
  localparam int POS_PARITY = 0;
  // Upper bits echoed in every serial answer
  localparam int ECHO_HI = 15;
  localparam int ECHO_LO = 11;
  // Fault flag and power-on flag set, parity makes the ones count odd
  localparam logic [15:0] STATUS_RESET = 16'hC001;
  // Bits that the summary fault flag ignores: the flag itself, key level, unused, parity
  localparam logic [15:0] FAULT_IGNORE = 16'h8481;

  // Bit 0 value that makes the whole word hold an odd number of ones
  function automatic logic odd_fill(input logic [15:0] word);
    odd_fill = ~^word[15:1];
  endfunction : odd_fill

  // OR of every fault bit below the summary flag
  function automatic logic any_fault(input logic [15:0] word);
    any_fault = |(word & ~FAULT_IGNORE);
  endfunction : any_fault
endpackage : fault_status_pkg

// ### fault_status_summary_register.sv
// Fault summary word: gathers flags and answers serial reads
// Summary of operation
// - Top bit set when any other fault
// - Key switch level never touches fault flag
// - Bit zero makes word ones count odd
// - Drain-source flag ORs six switch faults
// - Supply, logic and boot flags are ORs
// - Direct flags follow own condition, bit 7 zero
// - Reset reads fault, power-on and parity set only
// - Every read echoes top five status bits
`timescale 1ns/10ps
module fault_status_summary_register
  import fault_status_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic key_switch_pin,
  input wire logic xfer_error_flag,
  input wire logic nvm_fault_flag,
  input wire logic overcurrent_flag,
  input wire logic overheat_flag,
  input wire logic heat_alert_flag,
  input wire logic mcu_watchdog_flag,
  input wire logic enable_timeout_flag,
  input wire logic main_supply_low,
  input wire logic gate_reg_low,
  input wire logic logic_reg_low,
  input wire logic io_rail_low,
  input wire logic phase_a_boot_low,
  input wire logic phase_b_boot_low,
  input wire logic phase_c_boot_low,
  input wire logic phase_a_high_vds_fault,
  input wire logic phase_a_low_vds_fault,
  input wire logic phase_b_high_vds_fault,
  input wire logic phase_b_low_vds_fault,
  input wire logic phase_c_high_vds_fault,
  input wire logic phase_c_low_vds_fault,
  input wire logic rd_req,
  input wire logic rd_status,
  input wire logic [9:0] acq_data,
  input wire logic wr_req,
  input wire logic [15:0] wr_data,
  output logic [15:0] fault_summary_word,
  output logic [15:0] tx_word,
  output logic tx_valid
);
  status_frame_if fr ();
  logic key_s1;
  logic key_s2;
  logic key_s3;
  logic key_switch_level;
  logic por_flag;
  logic [15:0] next_status;
  logic [5:0] vds_faults;

  assign vds_faults = {phase_a_high_vds_fault, phase_a_low_vds_fault, phase_b_high_vds_fault,
                       phase_b_low_vds_fault, phase_c_high_vds_fault, phase_c_low_vds_fault};

  // Key switch is a pin: three stages, level taken once stages two and three agree
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      key_s1 <= 1'b0;
      key_s2 <= 1'b0;
      key_s3 <= 1'b0;
    end
    else
    begin
      key_s1 <= key_switch_pin;
      key_s2 <= key_s1;
      key_s3 <= key_s2;
    end
  end

  // Filtered key level, one-cycle glitches between stages are held off
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      key_switch_level <= 1'b0;
    else if (key_s2 == key_s3)
      key_switch_level <= key_s2;
  end

  // Power-on flag stays until the host has read the status word once
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      por_flag <= 1'b1;
    else if (rd_req && rd_status)
      por_flag <= 1'b0;
  end

  // Assemble the word from live conditions; wr_data has no path here
  // no write path
  always_comb
  begin
    next_status = '0;
    next_status[POS_POR] = por_flag;
    next_status[POS_XFER_ERR] = xfer_error_flag;
    next_status[POS_NVM] = nvm_fault_flag;
    next_status[POS_OVERCURRENT] = overcurrent_flag;
    next_status[POS_OVERHEAT] = overheat_flag;
    next_status[POS_HEAT_ALERT] = heat_alert_flag;
    next_status[POS_WATCHDOG] = mcu_watchdog_flag;
    next_status[POS_ENABLE_TO] = enable_timeout_flag;
    next_status[POS_KEY_LEVEL] = key_switch_level;
    next_status[POS_SUPPLY_LOW] = main_supply_low | gate_reg_low;
    next_status[POS_LOGIC_LOW] = logic_reg_low | io_rail_low;
    next_status[POS_BOOT_LOW] = phase_a_boot_low | phase_b_boot_low | phase_c_boot_low;
    next_status[POS_VDS] = |vds_faults;
    next_status[POS_ANY_FAULT] = any_fault(next_status);
    next_status[POS_PARITY] = odd_fill(next_status);
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      fault_summary_word <= STATUS_RESET;
    else
      fault_summary_word <= next_status;
  end

  // Hand the registered word and read request to the framer
  assign fr.status = fault_summary_word;
  assign fr.acq = acq_data;
  assign fr.rd_req = rd_req;
  assign fr.rd_status = rd_status;
  assign fr.wr_req = wr_req;
  assign tx_word = fr.tx_word;
  assign tx_valid = fr.tx_valid;

  status_framer status_framer_i (
    .mclk(mclk),
    .reset(reset),
    .fr(fr)
  );

  // Summary flag covers power-on too, only key level, unused bit and parity left out
  a_fault_summary: assert property (@(posedge mclk) disable iff (reset)
    fault_summary_word[15] == |(fault_summary_word[14:1] & ~FAULT_IGNORE[14:1]))
    else $error("fault flag disagrees with other flags");

  // Key level moving alone must leave the summary flag still
  a_key_fault_free: assert property (@(posedge mclk) disable iff (reset)
    $changed(fault_summary_word[10]) && $stable(fault_summary_word[14:11])
    && $stable(fault_summary_word[9:1]) |-> $stable(fault_summary_word[15]))
    else $error("key level moved the fault flag");

  // Key level only moves once stages two and three agree
  a_key_filter: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) && $changed(key_switch_level) |-> $past(key_s2) == $past(key_s3)
    && key_switch_level == $past(key_s2))
    else $error("key level moved without agreeing stages");

  // Filtered key level reaches the word one cycle later
  a_key_to_word: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> fault_summary_word[10] == $past(key_switch_level))
    else $error("key level bit does not follow the filter");

  // Stored word always holds odd parity
  a_status_parity: assert property (@(posedge mclk) disable iff (reset)
    ^fault_summary_word) else $error("status parity not odd");

  // Switch faults, one cycle behind the inputs
  a_vds_summary: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> fault_summary_word[1] == $past(|vds_faults))
    else $error("drain-source flag not the OR of switch faults");

  // Supply and logic rail groups
  a_supply_groups: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> fault_summary_word[4] == $past(main_supply_low | gate_reg_low)
    && fault_summary_word[3] == $past(logic_reg_low | io_rail_low))
    else $error("supply group flag wrong");

  // Bootstrap group, any phase sets it
  a_boot_group: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> fault_summary_word[2]
    == $past(phase_a_boot_low | phase_b_boot_low | phase_c_boot_low))
    else $error("bootstrap group flag wrong");

  // Direct flags and the unused bit
  a_direct_flags: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> fault_summary_word[11] == $past(overcurrent_flag)
    && fault_summary_word[5] == $past(enable_timeout_flag) && !fault_summary_word[7])
    else $error("direct flag does not follow its condition");

  // Remaining direct flags
  a_direct_rest: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> fault_summary_word[13] == $past(xfer_error_flag)
    && fault_summary_word[12] == $past(nvm_fault_flag)
    && fault_summary_word[9] == $past(overheat_flag)
    && fault_summary_word[8] == $past(heat_alert_flag)
    && fault_summary_word[6] == $past(mcu_watchdog_flag))
    else $error("direct flag lost its condition");

  // Live flags may load at the first edge, so check the held value instead
  a_reset_word: assert property (@(posedge mclk) disable iff (reset)
    $past(reset) |-> $past(fault_summary_word) == STATUS_RESET && fault_summary_word[14])
    else $error("status not at reset value after reset");

  // Power-on flag only falls on a status read
  a_por_hold: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) && !$past(rd_req && rd_status) |-> por_flag == $past(por_flag))
    else $error("power-on flag changed without a status read");

  // Status read clears the power-on bit one edge on; checked two edges on
  a_por_clear: assert property (@(posedge mclk) disable iff (reset)
    rd_req && rd_status |-> ##2 !fault_summary_word[14])
    else $error("power-on flag survived a status read");

  // Writes leave the power-on flag alone
  a_write_keeps_por: assert property (@(posedge mclk) disable iff (reset)
    wr_req && !rd_req |=> por_flag == $past(por_flag))
    else $error("host write altered the power-on flag");
endmodule : fault_status_summary_register

// ### fault_status_summary_register_tb.sv
// Self-checking bench for the fault summary word
`timescale 1ns/10ps
module fault_status_summary_register_tb;
  import fault_status_pkg::*;
  typedef struct packed {logic key; logic [19:0] flags; logic [15:0] exp;} row_t;
  logic mclk, reset, key, rd_req, rd_status, wr_req, tx_valid, v;
  logic [19:0] flags;
  logic [9:0] acq_data, acq;
  logic [15:0] wr_data, fault_summary_word, tx_word, w, e;
  int n_errors, tests_run;
  // Single flags, grouped inputs and key level cases
  row_t rows [21] = '{'{1'b0, 20'h0_0000, 16'h0001}, '{1'b0, 20'h8_0000, 16'hA001},
    '{1'b0, 20'h4_0000, 16'h9001}, '{1'b0, 20'h2_0000, 16'h8801}, '{1'b0, 20'h1_0000, 16'h8201},
    '{1'b0, 20'h0_8000, 16'h8101}, '{1'b0, 20'h0_4000, 16'h8041}, '{1'b0, 20'h0_2000, 16'h8021},
    '{1'b0, 20'h0_1000, 16'h8011}, '{1'b0, 20'h0_0800, 16'h8011}, '{1'b0, 20'h0_0400, 16'h8009},
    '{1'b0, 20'h0_0200, 16'h8009}, '{1'b0, 20'h0_0100, 16'h8005}, '{1'b0, 20'h0_0080, 16'h8005},
    '{1'b0, 20'h0_0040, 16'h8005}, '{1'b0, 20'h0_0020, 16'h8003}, '{1'b0, 20'h0_000C, 16'h8003},
    '{1'b0, 20'h0_0013, 16'h8003}, '{1'b1, 20'h0_0000, 16'h0400}, '{1'b1, 20'h8_0000, 16'hA400},
    '{1'b0, 20'hC_0001, 16'hB003}};

  fault_status_summary_register fault_status_summary_register_i (.mclk(mclk),
    .reset(reset), .key_switch_pin(key), .xfer_error_flag(flags[19]),
    .nvm_fault_flag(flags[18]), .overcurrent_flag(flags[17]), .overheat_flag(flags[16]),
    .heat_alert_flag(flags[15]), .mcu_watchdog_flag(flags[14]),
    .enable_timeout_flag(flags[13]), .main_supply_low(flags[12]), .gate_reg_low(flags[11]),
    .logic_reg_low(flags[10]), .io_rail_low(flags[9]), .phase_a_boot_low(flags[8]),
    .phase_b_boot_low(flags[7]), .phase_c_boot_low(flags[6]),
    .phase_a_high_vds_fault(flags[5]), .phase_a_low_vds_fault(flags[4]),
    .phase_b_high_vds_fault(flags[3]), .phase_b_low_vds_fault(flags[2]),
    .phase_c_high_vds_fault(flags[1]), .phase_c_low_vds_fault(flags[0]),
    .rd_req(rd_req), .rd_status(rd_status), .acq_data(acq_data), .wr_req(wr_req),
    .wr_data(wr_data), .fault_summary_word(fault_summary_word), .tx_word(tx_word),
    .tx_valid(tx_valid));

  host_model host_model_i (.mclk(mclk), .tx_word(tx_word), .tx_valid(tx_valid),
    .rd_req(rd_req), .rd_status(rd_status), .acq_data(acq_data), .wr_req(wr_req),
    .wr_data(wr_data));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Free-running 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Watchdog sized well past the expected few hundred cycles
  initial
  begin
    #20000;
    n_errors++;
    final_report();
  end

  initial
  begin
    reset = 1'b1;
    key = 1'b0;
    flags = 20'h0_0000;
    repeat (6) @(negedge mclk);
    chk("reset word", fault_summary_word, 16'hC001);
    chk("reset valid", {15'h0, tx_valid}, 16'h0000);
    reset = 1'b0;
    // First status read returns the power-on word, then the flag clears
    host_model_i.read(1'b1, 10'h000, w, v);
    chk("por read", w, 16'hC001);
    @(negedge mclk);
    chk("por cleared", fault_summary_word, 16'h0001);
    // Row loop: status word, status read and acquisition read
    foreach (rows[i])
    begin
      flags = rows[i].flags;
      key = rows[i].key;
      e = rows[i].exp;
      repeat (6) @(negedge mclk);
      chk("word", fault_summary_word, e);
      host_model_i.read(1'b1, 10'h000, w, v);
      chk("status valid", {15'h0, v}, 16'h0001);
      chk("status tx", w, e);
      acq = 10'h155 ^ 10'(i);
      host_model_i.read(1'b0, acq, w, v);
      chk("acq tx", w, {e[15:11], acq, ~^{e[15:11], acq}});
    end
    // Write of the inverted word must neither answer nor alter
    host_model_i.write(~e, v);
    chk("write valid", {15'h0, v}, 16'h0000);
    chk("write tx", tx_word, {e[15:11], acq, ~^{e[15:11], acq}});
    repeat (2) @(negedge mclk);
    chk("write word", fault_summary_word, e);
    // Reset again in mid-run, async
    reset = 1'b1;
    #1;
    chk("rereset word", fault_summary_word, 16'hC001);
    chk("rereset tx", tx_word, 16'hC001);
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    // Power-on flag returns on top of the flags still raised
    @(negedge mclk);
    chk("rerelease word", fault_summary_word, 16'hF002);
    host_model_i.read(1'b1, 10'h000, w, v);
    chk("rerelease read", w, 16'hF002);
    final_report();
  end
endmodule : fault_status_summary_register_tb

// ### host_model.sv
// Host side model: issues status reads, acquisition reads and writes
`timescale 1ns/10ps
module host_model (
  input wire logic mclk,
  input wire logic [15:0] tx_word,
  input wire logic tx_valid,
  output logic rd_req,
  output logic rd_status,
  output logic [9:0] acq_data,
  output logic wr_req,
  output logic [15:0] wr_data
);
  // Idle bus at time zero
  initial
  begin
    rd_req = 1'b0;
    rd_status = 1'b0;
    acq_data = 10'h2AA;
    wr_req = 1'b0;
    wr_data = 16'h5555;
  end

  // Request held through its sampling edge, answer taken one cycle on
  task automatic read(input logic st, input logic [9:0] acq, output logic [15:0] w,
    output logic v);
    @(negedge mclk);
    rd_req = 1'b1;
    rd_status = st;
    acq_data = acq;
    @(negedge mclk);
    rd_req = 1'b0;
    acq_data = ~acq;  // Released, so no stale value lingers
    w = tx_word;
    v = tx_valid;
  endtask : read

  // Write strobe; the answer line must stay quiet
  task automatic write(input logic [15:0] d, output logic v);
    @(negedge mclk);
    wr_req = 1'b1;
    wr_data = {d[15:1], ~^d[15:1]};
    @(negedge mclk);
    wr_req = 1'b0;
    wr_data = ~wr_data;  // Released value inverted
    v = tx_valid;
  endtask : write
endmodule : host_model

// ### status_frame_if.sv
// Carrier between the status word logic and the serial answer framer
`timescale 1ns/10ps
interface status_frame_if;
  logic [15:0] status;
  logic [9:0] acq;
  logic rd_req;
  logic rd_status;
  logic wr_req;
  logic [15:0] tx_word;
  logic tx_valid;
  modport source (output status, acq, rd_req, rd_status, wr_req, input tx_word, tx_valid);
  modport framer (input status, acq, rd_req, rd_status, wr_req, output tx_word, tx_valid);
endinterface : status_frame_if

// ### status_framer.sv
// Builds each serial answer word with echoed status bits and odd parity
`timescale 1ns/10ps
module status_framer
  import fault_status_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  status_frame_if.framer fr
);
  logic [15:0] next_word;

  // Low field is status or acquisition data, top five bits always status
  always_comb
  begin
    next_word = '0;
    next_word[ECHO_HI:ECHO_LO] = fr.status[ECHO_HI:ECHO_LO];
    next_word[ECHO_LO-1:1] = fr.rd_status ? fr.status[ECHO_LO-1:1] : fr.acq;
    next_word[POS_PARITY] = odd_fill(next_word);
  end

  // Answer register, only a read loads it
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      fr.tx_word <= STATUS_RESET;
      fr.tx_valid <= 1'b0;
    end
    else
    begin
      fr.tx_valid <= fr.rd_req;
      if (fr.rd_req)
        fr.tx_word <= next_word;
    end
  end

  a_frame_parity: assert property (@(posedge mclk) disable iff (reset)
    fr.tx_valid |-> ^fr.tx_word) else $error("answer word parity not odd");
  a_frame_top_bits: assert property (@(posedge mclk) disable iff (reset)
    fr.rd_req |=> fr.tx_valid && fr.tx_word[15:11] == $past(fr.status[15:11]))
    else $error("answer top bits differ from status");
  a_write_no_answer: assert property (@(posedge mclk) disable iff (reset)
    fr.wr_req && !fr.rd_req |=> !fr.tx_valid && $stable(fr.tx_word))
    else $error("write produced an answer");
endmodule : status_framer
